// File: core/scfap_defs.svh
// constants of the serial configuration and transmit FIFO access port
// assumes inclusion by the package, the interface and the port modules
`ifndef SCFAP_DEFS_SVH
`define SCFAP_DEFS_SVH

// ****************************************************************
// header byte layout
// ****************************************************************
`define SCFAP_HDR_RW_BIT 7
`define SCFAP_HDR_BURST_BIT 6
`define SCFAP_BYTE_LAST_BIT 3'h7

// ****************************************************************
// address map
// ****************************************************************
`define SCFAP_CFG_LAST 6'h2E
`define SCFAP_CFG_COUNT 47
`define SCFAP_STAT_FIRST 6'h30
`define SCFAP_STAT_LAST 6'h3D
`define SCFAP_PA_ADDR 6'h3E
`define SCFAP_FIFO_ADDR 6'h3F
`define SCFAP_RADIO_STATE_REG 6'h35
`define SCFAP_TX_FILL_REG 6'h3A

// ****************************************************************
// command strobes
// ****************************************************************
`define SCFAP_STB_SOFT_RESET 6'h30
`define SCFAP_STB_FAST_TX 6'h31
`define SCFAP_STB_OSC_OFF 6'h32
`define SCFAP_STB_CALIBRATE 6'h33
`define SCFAP_STB_TX 6'h35
`define SCFAP_STB_GO_IDLE 6'h36
`define SCFAP_STB_POWER_DOWN 6'h39
`define SCFAP_STB_FLUSH_TX 6'h3B
`define SCFAP_STB_NOP 6'h3D

// ****************************************************************
// status byte and sizes
// ****************************************************************
`define SCFAP_ST_IDLE 3'h0
`define SCFAP_ST_UNDERFLOW 3'h7
`define SCFAP_FREE_MAX 7'h0F
`define SCFAP_FIFO_DEPTH 64
`define SCFAP_FIFO_AW 6
`define SCFAP_FIFO_CW 7
`define SCFAP_PA_ENTRIES 2

`endif

// File: core/scfap_pkg.sv
// types of the serial configuration and transmit FIFO access port
// assumes scfap_defs.svh is on the include path
package scfap_pkg;
  `include "scfap_defs.svh"

  typedef enum logic [1:0] {
    PH_HDR = 2'h0,
    PH_WR = 2'h1,
    PH_RD = 2'h3
  } scfap_phase_e;

  typedef logic [`SCFAP_CFG_COUNT-1:0][7:0] scfap_cfg_t;
  typedef logic [`SCFAP_PA_ENTRIES-1:0][7:0] scfap_pa_t;

  typedef struct packed {
    logic ff1;
    logic ff2;
    logic ff3;
    logic level;
  } scfap_sync_s;

  typedef struct packed {
    logic [`SCFAP_FIFO_DEPTH-1:0][7:0] mem;
    logic [`SCFAP_FIFO_AW-1:0] wr_ptr;
    logic [`SCFAP_FIFO_AW-1:0] rd_ptr;
    logic [`SCFAP_FIFO_CW-1:0] count;
    logic [7:0] rdata;
    logic rvalid;
  } scfap_fifo_s;

  typedef struct packed {
    scfap_phase_e phase;
    logic [2:0] bit_cnt;
    logic [7:0] shift_in;
    logic [7:0] out_sh;
    logic so;
    logic so_oe;
    logic rw;
    logic burst;
    logic [5:0] addr;
    logic pa_idx;
    scfap_pa_t pa;
    scfap_cfg_t cfg;
    logic strobe_valid;
    logic [5:0] strobe_code;
    logic idle_pend;
    logic defer_valid;
    logic [5:0] defer_code;
    logic fifo_push;
    logic [7:0] fifo_wdata;
    logic fifo_flush;
    logic sclk_d;
    logic csn_d;
  } scfap_core_s;
endpackage

// File: core/scfap_fifo_if.sv
// link between the port core and the transmit FIFO storage
// assumes both ends run on the same system clock
`timescale 1ns/1ps
interface scfap_fifo_if;
  `include "scfap_defs.svh"
  logic push;
  logic [7:0] wdata;
  logic flush;
  logic pop;
  logic [7:0] rdata;
  logic rvalid;
  logic [`SCFAP_FIFO_CW-1:0] count;
  modport core (output push, output wdata, output flush, output pop,
                input rdata, input rvalid, input count);
  modport store (input push, input wdata, input flush, input pop,
                 output rdata, output rvalid, output count);
endinterface

// File: core/scfap_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes an asynchronous pin and the system clock
`timescale 1ns/1ps
module scfap_sync #(
  parameter logic RESET_LEVEL = 1'b0
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic pin_in,
  output logic level_out
);
  import scfap_pkg::*;

  scfap_sync_s st_reg;
  scfap_sync_s st_next;

  // ****************************************************************
  // stages
  // ****************************************************************
  always_comb begin
    st_next = st_reg;
    st_next.ff1 = pin_in;
    st_next.ff2 = st_reg.ff1;
    st_next.ff3 = st_reg.ff2;
    if (st_reg.ff2 == st_reg.ff3) begin
      st_next.level = st_reg.ff3;
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      st_reg <= {4{RESET_LEVEL}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_out = st_reg.level;
endmodule

// File: core/scfap_fifo_store.sv
// transmit FIFO storage in flip-flops, registered read port
// assumes the core refuses nothing; a push into a full store is dropped
`timescale 1ns/1ps
module scfap_fifo_store (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  scfap_fifo_if.store fifo
);
  import scfap_pkg::*;

  scfap_fifo_s st_reg;
  scfap_fifo_s st_next;
  logic push_ok;
  logic pop_ok;

  // ****************************************************************
  // pointers and storage
  // ****************************************************************
  always_comb begin
    st_next = st_reg;
    st_next.rvalid = 1'b0;
    push_ok = fifo.push && (st_reg.count < `SCFAP_FIFO_CW'(`SCFAP_FIFO_DEPTH));
    pop_ok = fifo.pop && (st_reg.count != '0);
    if (fifo.flush) begin
      st_next.wr_ptr = '0;
      st_next.rd_ptr = '0;
      st_next.count = '0;
    end else begin
      if (push_ok) begin
        st_next.mem[st_reg.wr_ptr] = fifo.wdata;
        st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
      end
      if (pop_ok) begin
        st_next.rdata = st_reg.mem[st_reg.rd_ptr];
        st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
        st_next.rvalid = 1'b1;
      end
      st_next.count = st_reg.count + `SCFAP_FIFO_CW'(push_ok) - `SCFAP_FIFO_CW'(pop_ok);
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign fifo.rdata = st_reg.rdata;
  assign fifo.rvalid = st_reg.rvalid;
  assign fifo.count = st_reg.count;
endmodule

// File: core/scfap_port.sv
// serial configuration and transmit FIFO access port, slave side
// assumes serial pins asynchronous to sys_clk_in, clocked at most an eighth of its rate
`timescale 1ns/1ps
`include "scfap_defs.svh"

module scfap_port #(
  parameter int FIFO_DEPTH = `SCFAP_FIFO_DEPTH
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic sclk_in,
  input wire logic chip_select_low_in,
  input wire logic si_in,
  output logic so_out,
  output logic so_oe_out,
  input wire logic osc_stable_in,
  input wire logic [2:0] radio_state_in,
  input wire logic sleep_entry_in,
  input wire logic tx_pop_in,
  output logic [7:0] tx_data_out,
  output logic tx_data_valid_out,
  output logic [`SCFAP_FIFO_CW-1:0] tx_count_out,
  output logic strobe_valid_out,
  output logic [5:0] strobe_code_out,
  output scfap_pkg::scfap_cfg_t cfg_regs_out,
  output logic [7:0] pa_low_out,
  output logic [7:0] pa_high_out
);
  import scfap_pkg::*;

  if (FIFO_DEPTH != `SCFAP_FIFO_DEPTH) begin : g_depth_check
    $error("scfap_port: FIFO_DEPTH must equal the storage depth");
  end

  scfap_core_s st_reg;
  scfap_core_s st_next;
  logic sclk_s;
  logic csn_s;
  logic si_s;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  logic byte_done;
  logic [7:0] rx_byte;
  logic [7:0] status;
  logic [`SCFAP_FIFO_CW-1:0] space;
  logic [3:0] free_cnt;

  scfap_fifo_if fifo ();

  // ****************************************************************
  // pin synchronisers and fifo storage
  // ****************************************************************
  scfap_sync #(.RESET_LEVEL(1'b0)) u_sync_sclk (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .pin_in(sclk_in),
    .level_out(sclk_s)
  );
  scfap_sync #(.RESET_LEVEL(1'b1)) u_sync_csn (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .pin_in(chip_select_low_in),
    .level_out(csn_s)
  );
  scfap_sync #(.RESET_LEVEL(1'b0)) u_sync_si (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .pin_in(si_in),
    .level_out(si_s)
  );
  scfap_fifo_store u_store (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .fifo(fifo.store)
  );

  assign fifo.push = st_reg.fifo_push;
  assign fifo.wdata = st_reg.fifo_wdata;
  assign fifo.flush = st_reg.fifo_flush;
  assign fifo.pop = tx_pop_in;

  // ****************************************************************
  // edges, received byte and status byte
  // ****************************************************************
  assign sclk_rise = sclk_s && !st_reg.sclk_d;
  assign sclk_fall = !sclk_s && st_reg.sclk_d;
  assign cs_rise = csn_s && !st_reg.csn_d;
  assign byte_done = !csn_s && sclk_rise && (st_reg.bit_cnt == `SCFAP_BYTE_LAST_BIT);
  assign rx_byte = {st_reg.shift_in[6:0], si_s};
  assign space = `SCFAP_FIFO_CW'(FIFO_DEPTH) - fifo.count;
  assign free_cnt = (space > `SCFAP_FREE_MAX) ? 4'hF : space[3:0];
  assign status = {!osc_stable_in, radio_state_in, free_cnt};

  function automatic logic [7:0] read_mux(input logic [5:0] a, input logic b,
                                          input logic idx, input scfap_cfg_t cfg,
                                          input scfap_pa_t pa, input logic [2:0] rstate,
                                          input logic [`SCFAP_FIFO_CW-1:0] cnt);
    logic [7:0] val;
    val = 8'h00;
    if (a <= `SCFAP_CFG_LAST) begin
      val = cfg[a];
    end else if (a == `SCFAP_PA_ADDR) begin
      val = pa[idx];
    end else if (b && a == `SCFAP_RADIO_STATE_REG) begin
      val = {5'h00, rstate};
    end else if (b && a == `SCFAP_TX_FILL_REG) begin
      val = {1'b0, cnt};
    end
    return val;
  endfunction

  function automatic logic known_strobe(input logic [5:0] a);
    logic hit;
    hit = 1'b0;
    case (a)
      `SCFAP_STB_SOFT_RESET, `SCFAP_STB_FAST_TX, `SCFAP_STB_OSC_OFF,
      `SCFAP_STB_CALIBRATE, `SCFAP_STB_TX, `SCFAP_STB_GO_IDLE,
      `SCFAP_STB_POWER_DOWN, `SCFAP_STB_FLUSH_TX, `SCFAP_STB_NOP: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  // ****************************************************************
  // transfer engine
  // ****************************************************************
  always_comb begin
    logic [5:0] hdr_addr;
    logic single_end;
    hdr_addr = rx_byte[5:0];
    single_end = 1'b0;
    st_next = st_reg;
    st_next.strobe_valid = 1'b0;
    st_next.fifo_push = 1'b0;
    st_next.fifo_flush = 1'b0;
    st_next.sclk_d = sclk_s;
    st_next.csn_d = csn_s;
    if (st_reg.idle_pend && radio_state_in == `SCFAP_ST_IDLE) begin
      st_next.idle_pend = 1'b0;
    end
    if (sleep_entry_in) begin
      st_next.fifo_flush = 1'b1;
      st_next.pa[1] = 8'h00;
    end
    if (csn_s) begin
      st_next.phase = PH_HDR;
      st_next.bit_cnt = 3'h0;
      st_next.so = 1'b0;
      st_next.so_oe = 1'b0;
      st_next.pa_idx = 1'b0;
      if (cs_rise && st_reg.defer_valid) begin
        st_next.defer_valid = 1'b0;
        if (!st_reg.idle_pend) begin
          st_next.strobe_valid = 1'b1;
          st_next.strobe_code = st_reg.defer_code;
        end
      end
    end else begin
      st_next.so_oe = 1'b1;
      if (st_reg.bit_cnt == 3'h0 && st_reg.phase != PH_RD) begin
        st_next.so = status[7];
        st_next.out_sh = {status[6:0], 1'b0};
      end else if (sclk_fall) begin
        st_next.so = st_reg.out_sh[7];
        st_next.out_sh = {st_reg.out_sh[6:0], 1'b0};
      end
      if (sclk_rise) begin
        st_next.shift_in = rx_byte;
        st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
      end
      if (byte_done) begin
        case (st_reg.phase)
          PH_HDR: begin
            st_next.rw = rx_byte[`SCFAP_HDR_RW_BIT];
            st_next.burst = rx_byte[`SCFAP_HDR_BURST_BIT];
            st_next.addr = hdr_addr;
            if (!rx_byte[`SCFAP_HDR_BURST_BIT] && hdr_addr >= `SCFAP_STAT_FIRST
                && hdr_addr <= `SCFAP_STAT_LAST) begin
              if (!known_strobe(hdr_addr)) begin
                st_next.phase = PH_HDR;
              end else if (st_reg.idle_pend && hdr_addr != `SCFAP_STB_GO_IDLE) begin
                st_next.phase = PH_HDR;
              end else if (hdr_addr == `SCFAP_STB_POWER_DOWN
                           || hdr_addr == `SCFAP_STB_OSC_OFF) begin
                st_next.defer_valid = 1'b1;
                st_next.defer_code = hdr_addr;
              end else if (hdr_addr == `SCFAP_STB_FLUSH_TX) begin
                if (radio_state_in == `SCFAP_ST_IDLE
                    || radio_state_in == `SCFAP_ST_UNDERFLOW) begin
                  st_next.fifo_flush = 1'b1;
                  st_next.strobe_valid = 1'b1;
                  st_next.strobe_code = hdr_addr;
                end
              end else begin
                st_next.strobe_valid = 1'b1;
                st_next.strobe_code = hdr_addr;
                if (hdr_addr == `SCFAP_STB_GO_IDLE) begin
                  st_next.idle_pend = 1'b1;
                end
              end
            end else if (rx_byte[`SCFAP_HDR_RW_BIT]) begin
              st_next.phase = PH_RD;
              st_next.out_sh = read_mux(hdr_addr, rx_byte[`SCFAP_HDR_BURST_BIT],
                                        st_reg.pa_idx, st_reg.cfg, st_reg.pa,
                                        radio_state_in, fifo.count);
            end else begin
              st_next.phase = PH_WR;
            end
          end
          PH_WR, PH_RD: begin
            if (st_reg.phase == PH_WR) begin
              if (st_reg.addr <= `SCFAP_CFG_LAST) begin
                st_next.cfg[st_reg.addr] = rx_byte;
              end else if (st_reg.addr == `SCFAP_PA_ADDR) begin
                st_next.pa[st_reg.pa_idx] = rx_byte;
              end else if (st_reg.addr == `SCFAP_FIFO_ADDR) begin
                st_next.fifo_push = 1'b1;
                st_next.fifo_wdata = rx_byte;
              end
            end
            if (st_reg.addr == `SCFAP_PA_ADDR) begin
              st_next.pa_idx = !st_reg.pa_idx;
            end
            if (st_reg.addr <= `SCFAP_CFG_LAST) begin
              st_next.addr = st_reg.addr + 6'h01;
            end
            single_end = !st_reg.burst
                         || (st_reg.addr >= `SCFAP_STAT_FIRST && st_reg.addr <= `SCFAP_STAT_LAST);
            if (single_end) begin
              st_next.phase = PH_HDR;
            end else if (st_reg.phase == PH_RD) begin
              st_next.out_sh = read_mux(st_next.addr, st_reg.burst, st_next.pa_idx,
                                        st_reg.cfg, st_reg.pa, radio_state_in, fifo.count);
            end
          end
          default: begin
            st_next.phase = PH_HDR;
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      st_reg <= '0;
      // chip select idles high: no false deselect edge after reset
      st_reg.csn_d <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign so_out = st_reg.so;
  assign so_oe_out = st_reg.so_oe;
  assign tx_data_out = fifo.rdata;
  assign tx_data_valid_out = fifo.rvalid;
  assign tx_count_out = fifo.count;
  assign strobe_valid_out = st_reg.strobe_valid;
  assign strobe_code_out = st_reg.strobe_code;
  assign cfg_regs_out = st_reg.cfg;
  assign pa_low_out = st_reg.pa[0];
  assign pa_high_out = st_reg.pa[1];

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);

  cs_abort_a: assert property (cs_rise |=> st_reg.phase == PH_HDR
    && st_reg.bit_cnt == 3'h0 && !so_oe_out) else $error("deselect did not abandon");
  pa_index_a: assert property (cs_rise |=> st_reg.pa_idx == 1'b0)
    else $error("power table index not cleared");
  ready_flag_a: assert property ((!csn_s && st_reg.phase == PH_HDR
    && st_reg.bit_cnt == 3'h0) |=> so_out == !$past(osc_stable_in))
    else $error("ready flag wrong before header");
  burst_count_a: assert property ((byte_done && st_reg.phase == PH_WR
    && st_reg.burst && st_reg.addr < `SCFAP_CFG_LAST)
    |=> st_reg.addr == $past(st_reg.addr) + 6'h01) else $error("burst address not advanced");
  single_end_a: assert property ((byte_done && st_reg.phase != PH_HDR
    && !st_reg.burst) |=> st_reg.phase == PH_HDR) else $error("single access not ended");
  idle_hold_a: assert property ((st_reg.idle_pend && radio_state_in != `SCFAP_ST_IDLE)
    |=> !(st_reg.strobe_valid && st_reg.strobe_code != `SCFAP_STB_GO_IDLE))
    else $error("strobe passed while going idle");
  defer_exec_a: assert property ((byte_done && st_reg.phase == PH_HDR
    && !rx_byte[`SCFAP_HDR_BURST_BIT] && rx_byte[5:0] == `SCFAP_STB_POWER_DOWN
    && !st_reg.idle_pend) |=> !st_reg.strobe_valid && st_reg.defer_valid)
    else $error("power-down strobe not deferred");
  flush_gate_a: assert property ((st_reg.fifo_flush && !$past(sleep_entry_in))
    |-> ($past(radio_state_in) == `SCFAP_ST_IDLE
    || $past(radio_state_in) == `SCFAP_ST_UNDERFLOW)) else $error("flush outside idle");
  fifo_push_a: assert property ((byte_done && st_reg.phase == PH_WR
    && st_reg.addr == `SCFAP_FIFO_ADDR) |=> st_reg.fifo_push
    ##1 tx_count_out == $past(tx_count_out) + 7'h01 || $past(tx_count_out) == 7'h40
    || $past(tx_pop_in) || $past(st_reg.fifo_flush)) else $error("fifo byte not stored");
endmodule

// File: sim/scfap_host_model.sv
// serial master model that frames transfers for the access port
// assumes the system clock and the port's serial output pin
`timescale 1ns/1ps
module scfap_host_model (
  input wire logic sys_clk_in,
  input wire logic so_in,
  output logic sclk_out,
  output logic chip_select_low_out,
  output logic si_out
);
  logic sel_err = 1'b0;
  initial begin
    sclk_out = 1'b0;
    chip_select_low_out = 1'b1;
    si_out = 1'b0;
  end
  // ****************************************************************
  // frame and byte tasks
  // ****************************************************************
  // select, then hold the first clock edge until the ready flag is low
  task automatic sel();
    int n;
    n = 0;
    @(posedge sys_clk_in) chip_select_low_out <= 1'b0;
    repeat (6) @(posedge sys_clk_in);
    while (so_in !== 1'b0 && n < 400) begin
      @(posedge sys_clk_in);
      n++;
    end
    if (n >= 400) sel_err = 1'b1;
    repeat (4) @(posedge sys_clk_in);
  endtask
  // msb first, data changed after the falling edge, 4 clocks low and high
  task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      @(posedge sys_clk_in) si_out <= tx[i];
      repeat (3) @(posedge sys_clk_in);
      sclk_out <= 1'b1;
      repeat (4) @(posedge sys_clk_in);
      rx[i] = so_in;
      sclk_out <= 1'b0;
    end
  endtask
  // deselect ends a burst and the frame
  task automatic desel();
    @(posedge sys_clk_in) chip_select_low_out <= 1'b1;
    repeat (10) @(posedge sys_clk_in);
  endtask
endmodule

// File: sim/scfap_tb.sv
// self-checking bench for the serial access port
// assumes the host model under sim/ and the port sources under core/
`timescale 1ns/1ps
`include "scfap_defs.svh"
module testbench;
  import scfap_pkg::*;
  logic sys_clk, reset, osc, sleep, pop;
  logic [2:0] rstate;
  wire logic sclk, chip_select_low, si;
  logic so, so_oe, txv, stbv;
  logic [7:0] txd, pa_lo, pa_hi, r;
  logic [6:0] txc;
  logic [5:0] stbc, last_code;
  scfap_cfg_t cfg;
  logic [7:0] cfg_exp [47];
  logic [7:0] q[$];
  logic [7:0] rq[$];
  logic [5:0] imm [7] = '{`SCFAP_STB_SOFT_RESET, `SCFAP_STB_FAST_TX, `SCFAP_STB_CALIBRATE,
    `SCFAP_STB_TX, `SCFAP_STB_GO_IDLE, `SCFAP_STB_FLUSH_TX, `SCFAP_STB_NOP};
  int n_fail, cmp_count, n_stb, fill;
  scfap_host_model i_host (.sys_clk_in(sys_clk), .so_in(so), .sclk_out(sclk),
    .chip_select_low_out(chip_select_low), .si_out(si));
  scfap_port #(.FIFO_DEPTH(64)) i_dut (.sys_clk_in(sys_clk), .reset_in(reset),
    .sclk_in(sclk), .chip_select_low_in(chip_select_low), .si_in(si), .so_out(so), .so_oe_out(so_oe),
    .osc_stable_in(osc), .radio_state_in(rstate), .sleep_entry_in(sleep), .tx_pop_in(pop),
    .tx_data_out(txd), .tx_data_valid_out(txv), .tx_count_out(txc),
    .strobe_valid_out(stbv), .strobe_code_out(stbc), .cfg_regs_out(cfg),
    .pa_low_out(pa_lo), .pa_high_out(pa_hi));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (stbv === 1'b1) begin
      n_stb <= n_stb + 1;
      last_code <= stbc;
    end
  end
  // ****************************************************************
  // compare and access tasks
  // ****************************************************************
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk_b(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_c(input logic [6:0] got, input logic [6:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] st_exp();
    int f;
    f = 64 - fill;
    return {~osc, rstate, (f > 15) ? 4'hF : 4'(f)};
  endfunction
  task automatic frame(input logic [7:0] hdr);
    rq = {};
    i_host.sel();
    i_host.xfer(hdr, 8, r);
    chk_b(r, st_exp());
    foreach (q[k]) begin
      i_host.xfer(q[k], 8, r);
      if (hdr[7] == 1'b0) chk_b(r, st_exp());
      else rq.push_back(r);
      if (hdr == 8'h3F || hdr == 8'h7F) fill = (fill < 64) ? fill + 1 : 64;
    end
    i_host.desel();
  endtask
  task automatic strobe(input logic [5:0] code, input int add);
    int n0;
    n0 = n_stb;
    q = {};
    frame({2'b00, code});
    chk_c(7'(n_stb - n0), 7'(add));
    if (add > 0) chk_b({2'b00, last_code}, {2'b00, code});
  endtask
  task automatic chk_cfg();
    for (int k = 0; k < 47; k++) chk_b(cfg[k], cfg_exp[k]);
  endtask
  task automatic pops(input int n, input logic [7:0] base);
    for (int k = 0; k < n; k++) begin
      @(posedge sys_clk) pop <= 1'b1;
      @(posedge sys_clk) pop <= 1'b0;
      #1;
      chk_b({7'h00, txv}, 8'h01);
      chk_b(txd, base + 8'(k));
    end
  endtask
  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial begin
    repeat (60000) @(posedge sys_clk);
    n_fail++;
    summarize();
  end
  initial begin
    reset = 1'b1; osc = 1'b1; sleep = 1'b0; pop = 1'b0; rstate = 3'h0; fill = 0;
    foreach (cfg_exp[k]) cfg_exp[k] = 8'h00;
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk_cfg();
    chk_b(pa_lo, 8'h00);
    chk_b(pa_hi, 8'h00);
    osc <= 1'b0;
    fork
      i_host.sel();
      begin
        repeat (30) @(posedge sys_clk);
        chk_b({7'h00, so}, 8'h01);
        chk_b({7'h00, so_oe}, 8'h01);
        osc <= 1'b1;
      end
    join
    i_host.desel();
    chk_b({7'h00, so_oe}, 8'h00);
    foreach (imm[k]) strobe(imm[k], 1);
    for (int k = 0; k < 2; k++) begin
      i_host.sel();
      i_host.xfer((k == 0) ? 8'h39 : 8'h32, 8, r);
      repeat (10) @(posedge sys_clk);
      chk_b(8'(n_stb), 8'(7 + k));
      i_host.desel();
      chk_b(8'(n_stb), 8'(8 + k));
    end
    rstate <= 3'h2;
    strobe(`SCFAP_STB_GO_IDLE, 1);
    strobe(`SCFAP_STB_TX, 0);
    rstate <= 3'h0;
    strobe(`SCFAP_STB_NOP, 1);
    q = {8'hA5}; frame(8'h05); cfg_exp[5] = 8'hA5;
    q = {8'h11, 8'h22}; frame(8'h6D); cfg_exp[45] = 8'h11; cfg_exp[46] = 8'h22;
    q = {8'h77}; frame(8'h2F); frame(8'h70);
    i_host.sel(); i_host.xfer(8'h05, 8, r); i_host.xfer(8'h99, 5, r); i_host.desel();
    chk_cfg();
    q = {8'h00}; frame(8'h85); chk_b(rq[0], 8'hA5);
    q = {8'h00, 8'h00}; frame(8'hED); chk_b(rq[0], 8'h11); chk_b(rq[1], 8'h22);
    q = {}; for (int k = 0; k < 16; k++) q.push_back(8'h40 + 8'(k));
    frame(8'h7F);
    q = {8'h50}; frame(8'h3F);
    repeat (4) @(posedge sys_clk);
    chk_c(txc, 7'd17);
    pops(17, 8'h40);
    fill = 0;
    q = {}; for (int k = 0; k < 65; k++) q.push_back(8'(k));
    frame(8'h7F);
    chk_c(txc, 7'd64);
    rstate <= 3'h2; strobe(`SCFAP_STB_FLUSH_TX, 0); chk_c(txc, 7'd64);
    rstate <= 3'h7; strobe(`SCFAP_STB_FLUSH_TX, 1); fill = 0; chk_c(txc, 7'd0);
    for (int k = 3; k < 6; k++) begin
      rstate <= 3'(k);
      strobe(`SCFAP_STB_NOP, 1);
    end
    q = {8'h00}; frame(8'hF5); chk_b(rq[0], 8'h05);
    rstate <= 3'h0;
    q = {8'hC1, 8'hC2}; frame(8'h7E); chk_b(pa_lo, 8'hC1); chk_b(pa_hi, 8'hC2);
    q = {8'h00}; frame(8'hBE); chk_b(rq[0], 8'hC1);
    q = {8'h00, 8'h00}; frame(8'hFE); chk_b(rq[0], 8'hC1); chk_b(rq[1], 8'hC2);
    q = {8'hC3}; frame(8'h3E); chk_b(pa_lo, 8'hC3); chk_b(pa_hi, 8'hC2);
    q = {8'h01, 8'h02, 8'h03}; frame(8'h7F);
    q = {8'h00}; frame(8'hFA); chk_b(rq[0], 8'h03);
    @(posedge sys_clk) sleep <= 1'b1;
    @(posedge sys_clk) sleep <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk_c(txc, 7'd0);
    chk_b(pa_lo, 8'hC3);
    chk_b(pa_hi, 8'h00);
    chk_b({7'h00, i_host.sel_err}, 8'h00);
    summarize();
  end
endmodule
